// File: rtl/sfc_pkg.sv
package sfc_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam int unsigned ADDR_W        = 18;
    localparam logic [15:0] IDX_FORMAT    = 16'hff88;
    localparam logic [15:0] IDX_BITRATE   = 16'hff89;
    localparam logic [15:0] IDX_CONTROL   = 16'hff8a;
    localparam logic [15:0] IDX_TXBUF     = 16'hff8b;
    localparam logic [15:0] IDX_STATUS    = 16'hff8c;
    localparam logic [15:0] IDX_RXBUF     = 16'hff8d;
    localparam logic [15:0] IDX_SERTIMER  = 16'hffc3;
    localparam logic [15:0] IDX_CONTROL0  = 16'hffda;

    localparam logic [7:0]  FORMAT_RESET  = 8'h00;
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  STATUS_RESET  = 8'h84;
    localparam logic [7:0]  TXBUF_RESET   = 8'hff;
    localparam logic [7:0]  RXBUF_RESET   = 8'h00;
    localparam logic [7:0]  BITRATE_RESET = 8'hff;
    localparam logic [7:0]  SERTIMER_RESET = 8'hf8;
    localparam int unsigned SERTIMER_MPE_BIT = 2;

    // Status bit positions
    localparam int unsigned ST_TXE  = 7;
    localparam int unsigned ST_RXF  = 6;
    localparam int unsigned ST_OVR  = 5;
    localparam int unsigned ST_FRM  = 4;
    localparam int unsigned ST_PAR  = 3;
    localparam int unsigned ST_DONE = 2;
    localparam int unsigned ST_ADDR = 1;
    localparam int unsigned ST_MPBT = 0;

    // Prescaler terminal counts: divide by 1, 4, 16, 64
    localparam logic [5:0]  PS_TERM_1  = 6'h00;
    localparam logic [5:0]  PS_TERM_4  = 6'h03;
    localparam logic [5:0]  PS_TERM_16 = 6'h0f;
    localparam logic [5:0]  PS_TERM_64 = 6'h3f;

    localparam logic [3:0]  CHAR_BITS_8 = 4'h8;
    localparam logic [3:0]  CHAR_BITS_7 = 4'h7;
    localparam logic [1:0]  STOP_ONE    = 2'h1;
    localparam logic [1:0]  STOP_TWO    = 2'h2;

    typedef struct packed {
        logic       sync_mode;
        logic       seven_bit_char;
        logic       parity_on;
        logic       odd_parity;
        logic       two_stop;
        logic       multiproc_fmt;
        logic       prescale_sel_hi;
        logic       prescale_sel_lo;
    } sfc_format_t;

    typedef struct packed {
        logic       txe_irq_on;
        logic       rx_irq_on;
        logic       tx_on;
        logic       rx_on;
        logic       addr_wait_on;
        logic       tx_done_irq_on;
        logic       clk_src_ext;
        logic       clk_out_on;
    } sfc_control_t;

    typedef enum logic [2:0] {
        SFC_IDLE  = 3'b000,
        SFC_START = 3'b001,
        SFC_DATA  = 3'b010,
        SFC_EXTRA = 3'b011,
        SFC_STOP  = 3'b100
    } sfc_state_t;

endpackage

// File: rtl/sfc_prescaler.sv
`timescale 1ns/1ns
module sfc_prescaler
    import sfc_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_ce,
    input  wire logic [1:0] i_sel,
    output logic            o_tick
);
    logic [5:0] cnt_q;
    wire  [5:0] term = (i_sel == 2'h0) ? PS_TERM_1 :
                       (i_sel == 2'h1) ? PS_TERM_4 :
                       (i_sel == 2'h2) ? PS_TERM_16 : PS_TERM_64;
    wire        wrap = (cnt_q >= term);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q  <= 6'h00;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            cnt_q  <= wrap ? 6'h00 : cnt_q + 6'h01;
            o_tick <= wrap;
        end
    end
endmodule // sfc_prescaler

// File: rtl/sfc_serial_unit.sv
`timescale 1ns/1ns
module sfc_serial_unit
    import sfc_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_ce,
    input  wire logic              i_standby,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    input  wire logic              i_rxd,
    output logic                   o_txd,
    output logic                   o_txd_oe_n,
    output logic                   o_rxd_used,
    output logic                   o_sck,
    output logic                   o_tx_empty_irq,
    output logic                   o_rx_full_irq,
    output logic                   o_rx_err_irq,
    output logic                   o_tx_done_irq
);
    sfc_format_t  fmt_q;
    sfc_control_t ctrl_q;
    sfc_control_t ctrl_d;
    logic [7:0]   brr_q;
    logic [7:0]   txbuf_q;
    logic [7:0]   rxbuf_q;
    logic [7:0]   sertimer_q;
    logic [7:0]   stat_q;
    logic [7:0]   stat_d;
    logic         rxd_s;
    logic         ps_tick;

    sfc_sync #(
        .RESET_VAL (1'b1)
    ) u_rxd_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_async    (i_rxd),
        .o_sync     (rxd_s)
    );

    sfc_prescaler u_prescaler (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_sel      ({fmt_q.prescale_sel_hi, fmt_q.prescale_sel_lo}),
        .o_tick     (ps_tick)
    );

    // Effective format after mode and global enable
    wire       sync_mode = fmt_q.sync_mode;
    wire       mp_eff    = !sync_mode && fmt_q.multiproc_fmt && sertimer_q[SERTIMER_MPE_BIT];
    wire       par_eff   = !sync_mode && fmt_q.parity_on && !mp_eff;
    wire       odd_eff   = par_eff && fmt_q.odd_parity;
    wire       wait_eff  = mp_eff && ctrl_q.addr_wait_on;
    wire [3:0] char_bits = (!sync_mode && fmt_q.seven_bit_char) ? CHAR_BITS_7 : CHAR_BITS_8;
    wire [1:0] stop_bits = fmt_q.two_stop ? STOP_TWO : STOP_ONE;
    wire       has_extra = par_eff || mp_eff;
    wire [7:0] half_brr  = brr_q >> 1;

    // APB decode; one wait state, answer registered
    wire [15:0] idx       = i_paddr[ADDR_W-1:2];
    wire        access    = i_psel && i_penable;
    wire        hit_fmt   = (idx == IDX_FORMAT);
    wire        hit_brr   = (idx == IDX_BITRATE);
    wire        hit_ctrl  = (idx == IDX_CONTROL);
    wire        hit_txb   = (idx == IDX_TXBUF);
    wire        hit_stat  = (idx == IDX_STATUS);
    wire        hit_rxb   = (idx == IDX_RXBUF);
    wire        hit_st    = (idx == IDX_SERTIMER);
    wire        mapped    = hit_fmt | hit_brr | hit_ctrl | hit_txb | hit_stat | hit_rxb | hit_st;
    wire        wr_commit = access && o_pready && i_pwrite && i_pstrb[0] && mapped;
    wire [7:0]  wd        = i_pwdata[7:0];
    wire [7:0]  rd_byte   = hit_fmt  ? fmt_q :
                            hit_brr  ? brr_q :
                            hit_ctrl ? ctrl_q :
                            hit_txb  ? txbuf_q :
                            hit_stat ? stat_q :
                            hit_rxb  ? rxbuf_q :
                            hit_st   ? sertimer_q : 8'h00;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            o_pready  <= access && !o_pready;
            o_prdata  <= (access && !o_pready && !i_pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            o_pslverr <= access && !o_pready && !mapped;
        end
    end

    // Transmitter
    sfc_state_t tx_state_q;
    logic [7:0] tx_cnt_q;
    logic [3:0] tx_bit_q;
    logic [7:0] tx_sh_q;
    logic       tx_extra_q;
    wire        tx_bit_end = ps_tick && (tx_cnt_q == brr_q);
    wire        tx_load    = (tx_state_q == SFC_IDLE) && ctrl_q.tx_on && !stat_q[ST_TXE];
    wire        tx_last    = (tx_bit_q == char_bits - 4'h1);
    wire        tx_end     = tx_bit_end && (((tx_state_q == SFC_STOP) && (tx_bit_q == {2'b00, stop_bits} - 4'h1))
                             || (sync_mode && (tx_state_q == SFC_DATA) && tx_last));
    wire [7:0]  tx_data    = fmt_q.seven_bit_char && !sync_mode ? {1'b0, txbuf_q[6:0]} : txbuf_q;
    wire        tx_par     = (^tx_data) ^ odd_eff;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_state_q <= SFC_IDLE;
            tx_cnt_q   <= 8'h00;
            tx_bit_q   <= 4'h0;
            tx_sh_q    <= 8'h00;
            tx_extra_q <= 1'b0;
        end else if (i_ce) begin
            if (!ctrl_q.tx_on || i_standby) begin
                tx_state_q <= SFC_IDLE;
            end else if (tx_load) begin
                tx_sh_q    <= tx_data;
                tx_extra_q <= mp_eff ? stat_q[ST_MPBT] : tx_par;
                tx_cnt_q   <= 8'h00;
                tx_bit_q   <= 4'h0;
                tx_state_q <= sync_mode ? SFC_DATA : SFC_START;
            end else if (tx_state_q != SFC_IDLE && ps_tick) begin
                tx_cnt_q <= tx_bit_end ? 8'h00 : tx_cnt_q + 8'h01;
                if (tx_bit_end) begin
                    unique case (tx_state_q)
                        SFC_START: tx_state_q <= SFC_DATA;
                        SFC_DATA: begin
                            tx_sh_q  <= tx_sh_q >> 1;
                            tx_bit_q <= tx_last ? 4'h0 : tx_bit_q + 4'h1;
                            if (tx_last) begin
                                tx_state_q <= sync_mode ? SFC_IDLE : (has_extra ? SFC_EXTRA : SFC_STOP);
                            end
                        end
                        SFC_EXTRA: tx_state_q <= SFC_STOP;
                        SFC_STOP: begin
                            tx_bit_q <= tx_bit_q + 4'h1;
                            if (tx_end) begin
                                tx_state_q <= SFC_IDLE;
                            end
                        end
                        default: tx_state_q <= SFC_IDLE;
                    endcase
                end
            end
        end
    end

    logic txd_d;
    always_comb begin
        unique case (tx_state_q)
            SFC_START: txd_d = 1'b0;
            SFC_DATA:  txd_d = tx_sh_q[0];
            SFC_EXTRA: txd_d = tx_extra_q;
            default:   txd_d = 1'b1;
        endcase
    end

    // Receiver
    sfc_state_t rx_state_q;
    logic [7:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic       rx_extra_q;
    logic       rx_done_q;
    logic [7:0] rx_data_q;
    logic       rx_fe_q;
    logic       rx_pe_q;
    logic       rx_mpb_q;
    wire        rx_run     = ctrl_q.rx_on && !i_standby;
    wire        rx_bit_end = ps_tick && (rx_cnt_q == brr_q);
    wire        rx_half    = ps_tick && (rx_cnt_q == half_brr);
    wire        rx_last    = (rx_bit_q == char_bits - 4'h1);
    wire [7:0]  rx_shifted = {rxd_s, rx_sh_q[7:1]};
    wire [7:0]  rx_word    = (char_bits == CHAR_BITS_7) ? {1'b0, rx_sh_q[7:1]} : rx_sh_q;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_state_q <= SFC_IDLE;
            rx_cnt_q   <= 8'h00;
            rx_bit_q   <= 4'h0;
            rx_sh_q    <= 8'h00;
            rx_extra_q <= 1'b0;
            rx_done_q  <= 1'b0;
            rx_data_q  <= 8'h00;
            rx_fe_q    <= 1'b0;
            rx_pe_q    <= 1'b0;
            rx_mpb_q   <= 1'b0;
        end else if (i_ce) begin
            rx_done_q <= 1'b0;
            if (!rx_run) begin
                rx_state_q <= SFC_IDLE;
            end else begin
                if (rx_state_q != SFC_IDLE && ps_tick) begin
                    rx_cnt_q <= (rx_bit_end || (rx_state_q == SFC_START && rx_half)) ? 8'h00 : rx_cnt_q + 8'h01;
                end
                unique case (rx_state_q)
                    SFC_IDLE: begin
                        rx_cnt_q <= 8'h00;
                        rx_bit_q <= 4'h0;
                        if (sync_mode || !rxd_s) begin
                            rx_state_q <= sync_mode ? SFC_DATA : SFC_START;
                        end
                    end
                    SFC_START: if (rx_half) begin
                        rx_state_q <= rxd_s ? SFC_IDLE : SFC_DATA; // Glitch rejected
                    end
                    SFC_DATA: if (rx_bit_end) begin
                        rx_sh_q  <= rx_shifted;
                        rx_bit_q <= rx_last ? 4'h0 : rx_bit_q + 4'h1;
                        if (rx_last && sync_mode) begin
                            rx_state_q <= SFC_IDLE;
                            rx_done_q  <= 1'b1;
                            rx_data_q  <= rx_shifted;
                            rx_fe_q    <= 1'b0;
                            rx_pe_q    <= 1'b0;
                            rx_mpb_q   <= 1'b0;
                        end else if (rx_last) begin
                            rx_state_q <= has_extra ? SFC_EXTRA : SFC_STOP;
                        end
                    end
                    SFC_EXTRA: if (rx_bit_end) begin
                        rx_extra_q <= rxd_s;
                        rx_state_q <= SFC_STOP;
                    end
                    SFC_STOP: if (rx_bit_end) begin
                        // Second stop bit never sampled; a low there is a new start
                        rx_state_q <= SFC_IDLE;
                        rx_done_q  <= 1'b1;
                        rx_data_q  <= rx_word;
                        rx_fe_q    <= !rxd_s;
                        rx_pe_q    <= par_eff && (((^rx_word) ^ rx_extra_q) != odd_eff);
                        rx_mpb_q   <= mp_eff && rx_extra_q;
                    end
                    default: rx_state_q <= SFC_IDLE;
                endcase
            end
        end
    end

    // Address-wait filter and status updates
    wire rx_drop   = rx_done_q && wait_eff && !rx_mpb_q;
    wire rx_addr   = rx_done_q && wait_eff && rx_mpb_q;
    wire rx_accept = rx_done_q && !rx_drop;
    wire rx_ovr    = rx_accept && stat_q[ST_RXF];
    wire rx_store  = rx_accept && !stat_q[ST_RXF];
    wire rx_good   = rx_store && !rx_fe_q && !rx_pe_q;
    wire [7:0] sw_clr = (wr_commit && hit_stat) ? ~wd : 8'h00;

    // Set wins over a software clear in the same cycle
    always_comb begin
        stat_d = stat_q;
        stat_d[ST_TXE]  = (stat_q[ST_TXE] && !sw_clr[ST_TXE]) || tx_load || !ctrl_q.tx_on;
        stat_d[ST_DONE] = (stat_q[ST_DONE] && !sw_clr[ST_TXE] && !tx_load)
                          || (tx_end && stat_q[ST_TXE]) || !ctrl_q.tx_on;
        stat_d[ST_RXF]  = (stat_q[ST_RXF] && !sw_clr[ST_RXF]) || rx_good;
        stat_d[ST_OVR]  = (stat_q[ST_OVR] && !sw_clr[ST_OVR]) || rx_ovr;
        stat_d[ST_FRM]  = (stat_q[ST_FRM] && !sw_clr[ST_FRM]) || (rx_store && rx_fe_q && !sync_mode);
        stat_d[ST_PAR]  = (stat_q[ST_PAR] && !sw_clr[ST_PAR]) || (rx_store && rx_pe_q);
        stat_d[ST_ADDR] = rx_accept && mp_eff ? rx_mpb_q : stat_q[ST_ADDR];
        stat_d[ST_MPBT] = (wr_commit && hit_stat) ? wd[ST_MPBT] : stat_q[ST_MPBT];
        if (i_standby) begin
            stat_d = STATUS_RESET;
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_commit && hit_ctrl) begin
            ctrl_d = sfc_control_t'(wd);
        end
        if (rx_addr) begin
            ctrl_d.addr_wait_on = 1'b0;
        end
        if (i_standby) begin
            ctrl_d = sfc_control_t'(CONTROL_RESET);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fmt_q      <= sfc_format_t'(FORMAT_RESET);
            ctrl_q     <= sfc_control_t'(CONTROL_RESET);
            brr_q      <= BITRATE_RESET;
            txbuf_q    <= TXBUF_RESET;
            rxbuf_q    <= RXBUF_RESET;
            sertimer_q <= SERTIMER_RESET;
            stat_q     <= STATUS_RESET;
        end else if (i_ce) begin
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            if (i_standby) begin
                fmt_q   <= sfc_format_t'(FORMAT_RESET);
                brr_q   <= BITRATE_RESET;
                txbuf_q <= TXBUF_RESET;
                rxbuf_q <= RXBUF_RESET;
            end else begin
                if (wr_commit && hit_fmt) fmt_q <= sfc_format_t'(wd);
                if (wr_commit && hit_brr) brr_q <= wd;
                if (wr_commit && hit_txb) txbuf_q <= wd;
                if (rx_store) rxbuf_q <= rx_data_q;
            end
            if (wr_commit && hit_st) sertimer_q <= wd;
        end
    end

    // Pins and requests, all registered; requests track next flag and enable
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_txd          <= 1'b1;
            o_txd_oe_n     <= 1'b1;
            o_rxd_used     <= 1'b0;
            o_sck          <= 1'b1;
            o_tx_empty_irq <= 1'b0;
            o_rx_full_irq  <= 1'b0;
            o_rx_err_irq   <= 1'b0;
            o_tx_done_irq  <= 1'b0;
        end else if (i_ce) begin
            o_txd          <= txd_d;
            o_txd_oe_n     <= !ctrl_d.tx_on;
            o_rxd_used     <= ctrl_d.rx_on;
            o_sck          <= !(sync_mode && tx_state_q == SFC_DATA && tx_cnt_q <= half_brr);
            o_tx_empty_irq <= stat_d[ST_TXE] && ctrl_d.txe_irq_on;
            o_rx_full_irq  <= stat_d[ST_RXF] && ctrl_d.rx_irq_on;
            o_rx_err_irq   <= (stat_d[ST_OVR] || stat_d[ST_FRM] || stat_d[ST_PAR]) && ctrl_d.rx_irq_on;
            o_tx_done_irq  <= stat_d[ST_DONE] && ctrl_d.tx_done_irq_on;
        end
    end
endmodule // sfc_serial_unit

// File: rtl/sfc_sync.sv
`timescale 1ns/1ns
module sfc_sync
    import sfc_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic i_core_clk,
    input  wire logic i_resetn,
    input  wire logic i_ce,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_q;

    // First stage feeds only the second
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else if (i_ce) begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // sfc_sync

// File: verif/sfc_peer_model.sv
`timescale 1ns/1ns
module sfc_peer_model (
    input  wire logic i_core_clk,
    input  wire logic i_txd,
    output logic      o_rxd
);
    int bit_t = 4;
    // Line idles high as with a pull-up
    initial o_rxd = 1'b1;
    task automatic send(input logic [11:0] frm, input int n);
        for (int i = -1; i < n; i++) begin
            o_rxd <= (i < 0) ? 1'b0 : frm[i];
            repeat (bit_t) @(posedge i_core_clk);
        end
        o_rxd <= 1'b1;
    endtask
    // Mid-bit sampling, so a wrong divider garbles the frame
    task automatic catch_frame(input int n, output logic [11:0] frm);
        frm = 12'h000;
        @(negedge i_txd);
        repeat (bit_t / 2) @(posedge i_core_clk);
        for (int i = 0; i < n; i++) begin
            repeat (bit_t) @(posedge i_core_clk);
            frm[i] = i_txd;
        end
    endtask
endmodule // sfc_peer_model

// File: verif/sfc_serial_unit_sva.sv
`timescale 1ns/1ns
module sfc_serial_unit_sva
    import sfc_pkg::*;
(
    input wire logic              i_core_clk,
    input wire logic              i_resetn,
    input wire logic              i_standby,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0]       i_pwdata,
    input wire logic              o_pready,
    input wire logic              o_txd_oe_n,
    input wire logic              o_rxd_used,
    input wire logic              o_tx_empty_irq,
    input wire logic              o_rx_full_irq,
    input wire logic              o_rx_err_irq,
    input wire logic              o_tx_done_irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    // Last control byte; pin owners lag it by a cycle at most
    logic [7:0] ctl_q;
    wire        ctl_wr = i_psel && i_penable && i_pwrite && o_pready && i_paddr[17:2] == IDX_CONTROL;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) ctl_q <= 8'h00;
        else if (ctl_wr) ctl_q <= i_pwdata[7:0];
    end
    a_tx_pin_own: assert property (ctl_wr |=> ##[0:1] o_txd_oe_n == !ctl_q[5])
        else $error("tx pin owner wrong");
    a_rx_pin_own: assert property (ctl_wr |=> ##[0:1] o_rxd_used == ctl_q[4])
        else $error("rx pin owner wrong");
    a_txe_irq_off: assert property (ctl_wr && !i_pwdata[7] |=> !o_tx_empty_irq)
        else $error("tx empty request stays");
    a_rx_irq_off: assert property (ctl_wr && !i_pwdata[6] |=> !o_rx_full_irq && !o_rx_err_irq)
        else $error("rx request stays");
    a_done_irq_off: assert property (ctl_wr && !i_pwdata[2] |=> !o_tx_done_irq)
        else $error("tx done request stays");
    a_standby_clr: assert property (i_standby ##1 i_standby |=> o_txd_oe_n && !o_rxd_used
        && !o_tx_empty_irq && !o_tx_done_irq) else $error("standby left control set");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held");
    a_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("ready late");
endmodule // sfc_serial_unit_sva

bind sfc_serial_unit sfc_serial_unit_sva sfc_serial_unit_sva_inst (.*);

// File: verif/sfc_serial_unit_tb.sv
`timescale 1ns/1ns
module sfc_serial_unit_tb;
    import sfc_pkg::*;
    logic              i_core_clk, i_resetn, i_ce, i_standby, i_psel, i_penable, i_pwrite, i_rxd;
    logic [ADDR_W-1:0] i_paddr;
    logic [31:0]       i_pwdata, o_prdata;
    logic [3:0]        i_pstrb;
    logic              o_pready, o_pslverr, o_txd, o_txd_oe_n, o_rxd_used, o_sck, err;
    logic              o_tx_empty_irq, o_rx_full_irq, o_rx_err_irq, o_tx_done_irq;
    logic [7:0]        rv, f, sync_rx;
    logic [11:0]       frx, ftx, got;
    int                failures = 0, samples_checked = 0, cycles = 0, n;
    // 8N1, 7N1, 8E2 /4, 8O1 /16, bad parity, mp without global on, /64
    localparam logic [7:0] WF [7] = '{8'h00, 8'h40, 8'h29, 8'h32, 8'h30, 8'h14, 8'h03};
    localparam logic [7:0] DT [7] = '{8'ha5, 8'hc3, 8'h37, 8'h5a, 8'h5a, 8'h96, 8'h0f};
    localparam logic [6:0] BAD    = 7'b0010000;
    sfc_serial_unit sfc_serial_unit_inst (.*);
    sfc_peer_model  sfc_peer_model_inst (.i_core_clk, .i_txd(o_txd), .o_rxd(i_rxd));
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    // Far end of a synchronous link shifts on the rising serial clock
    always @(posedge o_sck) sync_rx <= {o_txd, sync_rx[7:1]};
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] act);
        samples_checked++;
        if (act !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, act);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        int k;
        k = 0;
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, 2'b00, 24'h000000, d};
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 50);
        if (k >= 50) failures++;
        rv = o_prdata[7:0];
        err = o_pslverr;
        {i_psel, i_penable} <= 2'b00;
        @(posedge i_core_clk);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {4'h0, x}, {3'h0, err, rv});
    endtask
    // Stop bits stay 1; tail is the mp bit or parity, x flips parity
    function automatic logic [11:0] mk(input logic [7:0] f, input logic [7:0] d, input logic x, output int n);
        logic [11:0] r;
        int k;
        r = 12'hfff;
        k = f[6] ? 7 : 8;
        for (int i = 0; i < k; i++) r[i] = d[i];
        if (f[5] | f[2]) r[k] = f[2] ? x : ^(d & (f[6] ? 8'h7f : 8'hff)) ^ f[4] ^ x;
        n = k + (f[5] | f[2]) + 1 + f[3];
        return r;
    endfunction
    initial begin
        {i_resetn, i_standby, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        i_ce = 1'b1;
        i_pstrb = 4'hf;
        repeat (8) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        @(posedge i_core_clk);
        rdc(IDX_CONTROL, 8'h00);
        rdc(IDX_FORMAT, 8'h00);
        rdc(IDX_STATUS, 8'h84);
        apb(1'b0, 16'h0123, 8'h00);
        chk("unmapped", 12'h100, {3'h0, err, rv});
        apb(1'b1, IDX_CONTROL, 8'h80);
        chk("tx empty irq", 12'h001, {11'h0, o_tx_empty_irq});
        apb(1'b1, IDX_CONTROL, 8'h04);
        chk("irq pair", 12'h001, {10'h0, o_tx_empty_irq, o_tx_done_irq});
        apb(1'b1, IDX_CONTROL, 8'h30);
        @(posedge i_core_clk);
        chk("pins", 12'h001, {10'h0, o_txd_oe_n, o_rxd_used});
        apb(1'b1, IDX_BITRATE, 8'h03);
        for (int i = 0; i < 7; i++) begin
            f = WF[i] & 8'hfb;
            frx = mk(f, DT[i], BAD[i], n);
            ftx = mk(f, DT[i], 1'b0, n);
            sfc_peer_model_inst.bit_t = 4 << (2 * f[1:0]);
            apb(1'b1, IDX_FORMAT, WF[i]);
            apb(1'b1, IDX_CONTROL, 8'h70);
            sfc_peer_model_inst.send(frx, n);
            repeat (4) @(posedge i_core_clk);
            rdc(IDX_RXBUF, DT[i] & (f[6] ? 8'h7f : 8'hff));
            rdc(IDX_STATUS, BAD[i] ? 8'h8c : 8'hc4);
            chk("rx irqs", {10'h0, BAD[i], !BAD[i]}, {10'h0, o_rx_err_irq, o_rx_full_irq});
            apb(1'b1, IDX_STATUS, 8'h80);
            fork
                sfc_peer_model_inst.catch_frame(n, got);
                begin
                    apb(1'b1, IDX_TXBUF, DT[i]);
                    apb(1'b1, IDX_STATUS, 8'h78);
                end
            join
            chk("tx frame", ftx & ~(12'hfff << n), got);
            repeat (sfc_peer_model_inst.bit_t) @(posedge i_core_clk);
        end
        apb(1'b1, IDX_SERTIMER, 8'hfc);
        apb(1'b1, IDX_FORMAT, 8'h24);
        apb(1'b1, IDX_CONTROL, 8'h78);
        sfc_peer_model_inst.bit_t = 4;
        for (int j = 0; j < 2; j++) begin
            frx = mk(8'h24, 8'h11 * (j + 1), j[0], n);
            sfc_peer_model_inst.send(frx, n);
            repeat (4) @(posedge i_core_clk);
            rdc(IDX_RXBUF, j ? 8'h22 : 8'h0f);
            rdc(IDX_STATUS, j ? 8'hc6 : 8'h84);
        end
        rdc(IDX_CONTROL, 8'h70);
        // Low stop bit: first with the buffer still full, then with it empty
        apb(1'b1, IDX_FORMAT, 8'h00);
        for (int j = 0; j < 2; j++) begin
            sfc_peer_model_inst.send(12'h05a, 9);
            repeat (4) @(posedge i_core_clk);
            rdc(IDX_RXBUF, j ? 8'h5a : 8'h22);
            rdc(IDX_STATUS, j ? 8'h96 : 8'he6);
            chk("rx irqs", {10'h0, 1'b1, !j[0]}, {10'h0, o_rx_err_irq, o_rx_full_irq});
            apb(1'b1, IDX_STATUS, 8'h80);
        end
        // Synchronous mode sends all eight bits even with the length bit set
        apb(1'b1, IDX_CONTROL, 8'h20);
        apb(1'b1, IDX_FORMAT, 8'hc0);
        apb(1'b1, IDX_TXBUF, 8'ha5);
        apb(1'b1, IDX_STATUS, 8'h78);
        repeat (48) @(posedge i_core_clk);
        chk("sync frame", 12'h0a5, {4'h0, sync_rx});
        i_standby <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        i_standby <= 1'b0;
        @(posedge i_core_clk);
        rdc(IDX_CONTROL, 8'h00);
        final_report();
    end
endmodule // sfc_serial_unit_tb
